// file: inc/psol_defines.svh
/*
 output logic of the proximity switch: field codes, bit positions, timing counts.
 assumes a 125 MHz system clock.
*/
`ifndef PSOL_DEFINES_SVH
`define PSOL_DEFINES_SVH

`define PSOL_CLK_HZ 125000000
`define PSOL_MS_PER_S 1000
`define PSOL_TICK_CYC (`PSOL_CLK_HZ / `PSOL_MS_PER_S)
`define PSOL_DELAY_MAX_MS 60000
`define PSOL_FLASH_HZ 1
`define PSOL_FLASH_HALF_MS (`PSOL_MS_PER_S / (2 * `PSOL_FLASH_HZ))
`define PSOL_STEP_PCT 20
`define PSOL_STEP_MAX 3'h5
`define PSOL_PD_ANALOG_LO 2
`define PSOL_PD_START 5
`define PSOL_PD_TEMP 6
`define PSOL_PD_INSP 7
`define PSOL_PD_MARK_LO 8
`define PSOL_MARK_BYTES 32
`define PSOL_MARK_DEFAULT 8'h00
`define PSOL_DEF_CFG1 3'h0
`define PSOL_DEF_CFG2 3'h1
`define PSOL_DEF_STEP 3'h5

`endif

// file: inc/psol_pkg.sv
/*
 types of the proximity switch output logic.
 assumes the defines header is compiled alongside.
*/
package psol_pkg;
   typedef enum logic [2:0] {
      PSOL_PNP_NO, PSOL_PNP_NC, PSOL_NPN_NO, PSOL_NPN_NC,
      PSOL_PP_NO, PSOL_PP_NC, PSOL_TEMP_IND, PSOL_INSP_ALARM
   } psol_outcfg_t;
   typedef enum logic [1:0] {
      PSOL_FN_ONE, PSOL_FN_TWO, PSOL_FN_ANALOG, PSOL_FN_SPEED
   } psol_func_t;
   typedef enum logic [1:0] {PSOL_LED_SUPPLY, PSOL_LED_OUT_ONLY, PSOL_LED_OFF} psol_led_t;
   typedef enum logic [1:0] {PSOL_UNIT_C, PSOL_UNIT_F, PSOL_UNIT_K} psol_unit_t;
endpackage

// file: verilog/psol_delay.sv
/*
 delay filter: asserts after a qualifying on time, releases after an off time.
 assumes a one-cycle millisecond tick from the caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psol_defines.svh"
module psol_delay (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ms_tick,
   input wire logic raw,
   input wire logic [15:0] on_ms,
   input wire logic [15:0] off_ms,
   output logic filtered
);
   logic [15:0] count;
   logic last_raw;

   // count restarts on every change of the raw input
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= 16'h0000;
         last_raw <= 1'b0;
      end else begin
         last_raw <= raw;
         if (raw != last_raw) begin
            count <= 16'h0000;
         end else if (ms_tick && count != 16'hFFFF) begin
            count <= count + 16'h0001;
         end
      end
   end

   // short pulses never reach the output; short gaps are bridged
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         filtered <= 1'b0;
      end else if (raw == last_raw) begin
         // the first tick after a change is partial, so one extra tick is needed
         if (raw && (on_ms == 16'h0000 || count > on_ms)) begin
            filtered <= 1'b1;
         end else if (!raw && (off_ms == 16'h0000 || count > off_ms)) begin
            filtered <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: verilog/psol_top.sv
/*
 output processing of a two-output proximity switch: configuration, delays,
 alarms, marking memory, process data and led drive.
 assumes analog sensing supplies per-step detect levels and the temperature,
 and the protocol stack supplies parameter writes and reads.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psol_defines.svh"
module psol_top (
   input wire logic clk,
   input wire logic nrst,
   input wire logic standard_switching_mode,
   input wire psol_pkg::psol_func_t func,
   input wire psol_pkg::psol_outcfg_t cfg_out1,
   input wire psol_pkg::psol_outcfg_t cfg_out2,
   input wire logic [2:0] step_out1,
   input wire logic [2:0] step_out2,
   input wire logic hyst_small,
   input wire logic [15:0] assert_delay_time,
   input wire logic [15:0] release_delay_time,
   input wire logic [15:0] start_delay_time,
   input wire logic [5:1] detect_std,
   input wire logic [5:1] detect_small,
   input wire logic speed_in_window,
   input wire logic speed_above_min,
   input wire logic signed [15:0] temp_c,
   input wire logic signed [15:0] temp_low,
   input wire logic signed [15:0] temp_high,
   input wire psol_pkg::psol_unit_t temp_unit,
   input wire logic [31:0] hours_limit,
   input wire logic [31:0] cycles_limit,
   input wire logic hour_pulse,
   input wire psol_pkg::psol_led_t led_mode,
   input wire logic led_temp_en,
   input wire logic mark_we,
   input wire logic [4:0] mark_addr,
   input wire logic [7:0] mark_wdata,
   input wire logic param_rd,
   input wire logic [2:0] param_sel,
   output logic [31:0] param_rdata,
   output logic param_valid,
   output logic [15:0] process_data,
   output logic update_request,
   output logic out1_high_drive,
   output logic out1_low_drive,
   output logic out2_high_drive,
   output logic out2_low_drive,
   output logic led_green,
   output logic led_yellow
);
   import psol_pkg::*;

   function automatic logic step_hit(input logic [5:1] lv, input logic [2:0] st);
      logic hit;
      hit = 1'b0;
      if (st >= 3'h1 && st <= `PSOL_STEP_MAX) begin
         hit = lv[st];
      end
      return hit;
   endfunction

   function automatic logic [1:0] drive(input psol_outcfg_t c, input logic act);
      logic [1:0] d;
      logic on;
      on = (c == PSOL_PNP_NC || c == PSOL_NPN_NC || c == PSOL_PP_NC) ? !act : act;
      case (c)
         PSOL_PNP_NO, PSOL_PNP_NC: d = {on, 1'b0};
         PSOL_NPN_NO, PSOL_NPN_NC: d = {1'b0, on};
         PSOL_PP_NO, PSOL_PP_NC: d = {on, !on};
         default: d = {act, 1'b0};
      endcase
      return d;
   endfunction

   function automatic logic signed [31:0] to_unit(input logic signed [15:0] c,
                                                  input psol_unit_t u);
      logic signed [31:0] v;
      case (u)
         PSOL_UNIT_F: v = (32'(c) * 32'sd9) / 32'sd5 + 32'sd32;
         PSOL_UNIT_K: v = 32'(c) + 32'sd273;
         default: v = 32'(c);
      endcase
      return v;
   endfunction

   logic [16:0] tick_cnt;
   logic ms_tick;
   psol_outcfg_t act_cfg1;
   psol_outcfg_t act_cfg2;
   logic last_sio;
   logic [2:0] eff_step1;
   logic [2:0] eff_step2;
   logic corrected;
   logic last_corrected;
   logic [5:0] last_steps;
   logic raw1;
   logic raw2;
   logic filt1;
   logic sw1;
   logic sw2;
   logic sw1_q;
   logic temp_alarm;
   logic [31:0] hours;
   logic [31:0] cycles;
   logic insp_alarm;
   logic [15:0] start_cnt;
   logic starting;
   logic [7:0] mark_mem [0:`PSOL_MARK_BYTES-1];
   logic [2:0] analog_code;
   logic [9:0] flash_cnt;
   logic flash;
   logic temp_role_ok;

   // one-cycle millisecond tick
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt <= 17'h00000;
      end else if (tick_cnt == 17'(`PSOL_TICK_CYC - 1)) begin
         tick_cnt <= 17'h00000;
      end else begin
         tick_cnt <= tick_cnt + 17'h00001;
      end
   end
   assign ms_tick = (tick_cnt == 17'(`PSOL_TICK_CYC - 1));

   // configuration taken at reset release, every cycle of standard mode and the cycle it is left;
   // parameter retention across power loss lives in the stack's store
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         act_cfg1 <= psol_outcfg_t'(`PSOL_DEF_CFG1);
         act_cfg2 <= psol_outcfg_t'(`PSOL_DEF_CFG2);
         last_sio <= 1'b1;
      end else begin
         last_sio <= standard_switching_mode;
         if (last_sio != standard_switching_mode || last_sio) begin
            // reset, standard mode or mode switch: new output setting applies
            act_cfg1 <= cfg_out1;
            act_cfg2 <= cfg_out2;
         end
      end
   end

   // output 2 role restrictions
   assign temp_role_ok = !standard_switching_mode && func != PSOL_FN_TWO;

   // distance steps with output 1 forced above output 2, both set to step 3 in the speed function
   always_comb begin
      eff_step2 = (step_out2 >= 3'h1 && step_out2 <= `PSOL_STEP_MAX) ? step_out2
                  : `PSOL_DEF_STEP;
      eff_step1 = (step_out1 >= 3'h1 && step_out1 <= `PSOL_STEP_MAX) ? step_out1
                  : `PSOL_DEF_STEP;
      corrected = 1'b0;
      if (func == PSOL_FN_SPEED) begin
         eff_step1 = 3'h3;
         eff_step2 = 3'h3;
      end else if (eff_step1 <= eff_step2 && eff_step2 < `PSOL_STEP_MAX) begin
         eff_step1 = eff_step2 + 3'h1;
         corrected = 1'b1;
      end else if (eff_step1 <= eff_step2) begin
         eff_step1 = `PSOL_STEP_MAX;
         eff_step2 = `PSOL_STEP_MAX - 3'h1;
         corrected = 1'b1;
      end
   end

   // one-cycle update request when a correction begins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         last_corrected <= 1'b0;
         last_steps <= 6'h00;
         update_request <= 1'b0;
      end else begin
         last_corrected <= corrected;
         last_steps <= {step_out1, step_out2};
         // a new request that still clashes is a fresh correction
         update_request <= corrected &&
                           (!last_corrected || {step_out1, step_out2} != last_steps);
      end
   end

   // raw detection per function; small hysteresis only for single point
   always_comb begin
      raw1 = 1'b0;
      raw2 = 1'b0;
      case (func)
         PSOL_FN_ONE: begin
            raw1 = hyst_small ? step_hit(detect_small, eff_step1)
                              : step_hit(detect_std, eff_step1);
            raw2 = raw1;
         end
         PSOL_FN_TWO, PSOL_FN_ANALOG: begin
            raw1 = step_hit(detect_std, eff_step1);
            raw2 = step_hit(detect_std, eff_step2);
         end
         PSOL_FN_SPEED: begin
            raw1 = speed_above_min;
            raw2 = speed_in_window;
         end
         default: begin
            raw1 = 1'b0;
            raw2 = 1'b0;
         end
      endcase
   end

   psol_delay u_delay (
      .clk(clk),
      .nrst(nrst),
      .ms_tick(ms_tick),
      .raw(raw1),
      .on_ms(assert_delay_time),
      .off_ms(release_delay_time),
      .filtered(filt1)
   );

   // start delay after power up, speed monitor only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         start_cnt <= 16'h0000;
         starting <= 1'b1;
      end else if (func != PSOL_FN_SPEED || start_cnt >= start_delay_time) begin
         starting <= 1'b0;
      end else if (ms_tick) begin
         start_cnt <= start_cnt + 16'h0001;
      end
   end

   // temperature and counter alarms
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         temp_alarm <= 1'b0;
      end else begin
         temp_alarm <= temp_c < temp_low || temp_c > temp_high;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hours <= 32'h00000000;
         cycles <= 32'h00000000;
         sw1_q <= 1'b0;
      end else begin
         sw1_q <= sw1;
         if (hour_pulse && hours != 32'hFFFFFFFF) begin
            hours <= hours + 32'h00000001;
         end
         if (sw1 && !sw1_q && cycles != 32'hFFFFFFFF) begin
            cycles <= cycles + 32'h00000001;
         end
      end
   end
   assign insp_alarm = hours > hours_limit || cycles > cycles_limit;

   // switched state of each output before polarity
   always_comb begin
      sw1 = (func == PSOL_FN_ONE) ? filt1 : raw1;
      sw2 = raw2;
      if (act_cfg2 == PSOL_TEMP_IND) begin
         sw2 = temp_role_ok && temp_alarm;
      end else if (act_cfg2 == PSOL_INSP_ALARM) begin
         sw2 = !(standard_switching_mode && func == PSOL_FN_TWO) && insp_alarm;
      end
      if (starting && func == PSOL_FN_SPEED) begin
         sw1 = 1'b1;
         sw2 = 1'b1;
      end
   end

   // pin drivers from the latched configuration
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {out1_high_drive, out1_low_drive} <= 2'h0;
         {out2_high_drive, out2_low_drive} <= 2'h0;
      end else begin
         {out1_high_drive, out1_low_drive} <= drive(act_cfg1, sw1);
         {out2_high_drive, out2_low_drive} <= drive(act_cfg2, sw2);
      end
   end

   // marking memory; no reset so it maps to ram
   always_ff @(posedge clk) begin
      if (mark_we) begin
         mark_mem[mark_addr] <= mark_wdata;
      end
   end

   always_comb begin
      analog_code = 3'h0;
      casez ({step_hit(detect_std, 3'h1), step_hit(detect_std, 3'h2),
             step_hit(detect_std, 3'h3), step_hit(detect_std, 3'h4),
             step_hit(detect_std, 3'h5)})
         5'b1????: analog_code = 3'h5;
         5'b01???: analog_code = 3'h4;
         5'b001??: analog_code = 3'h3;
         5'b0001?: analog_code = 3'h2;
         5'b00001: analog_code = 3'h1;
         default: analog_code = 3'h0;
      endcase
   end

   // process data; reporting extras vanish in standard mode
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         process_data <= 16'h0000;
      end else begin
         process_data <= 16'h0000;
         process_data[0] <= sw1;
         process_data[1] <= sw2;
         process_data[`PSOL_PD_START] <= starting && func == PSOL_FN_SPEED;
         process_data[`PSOL_PD_INSP] <= insp_alarm;
         if (!standard_switching_mode) begin
            process_data[`PSOL_PD_TEMP] <= temp_alarm;
            process_data[`PSOL_PD_MARK_LO +: 8] <= mark_mem[0];
            if (func == PSOL_FN_ANALOG) begin
               process_data[`PSOL_PD_ANALOG_LO +: 3] <= analog_code;
            end
         end
      end
   end

   // acyclic reads: 0 temp, 1 low, 2 high, 3 hours, 4 cycles, 5 hours limit, 6 cycles limit, 7 marking
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         param_rdata <= 32'h00000000;
         param_valid <= 1'b0;
      end else begin
         param_valid <= param_rd && !standard_switching_mode;
         case (param_sel)
            3'h0: param_rdata <= to_unit(temp_c, temp_unit);
            3'h1: param_rdata <= to_unit(temp_low, temp_unit);
            3'h2: param_rdata <= to_unit(temp_high, temp_unit);
            3'h3: param_rdata <= hours;
            3'h4: param_rdata <= cycles;
            3'h5: param_rdata <= hours_limit;
            3'h6: param_rdata <= cycles_limit;
            default: param_rdata <= {24'h000000, mark_mem[mark_addr]};
         endcase
      end
   end

   // 1 Hz flash from the ms tick
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flash_cnt <= 10'h000;
         flash <= 1'b0;
      end else if (ms_tick && flash_cnt == 10'(`PSOL_FLASH_HALF_MS - 1)) begin
         flash_cnt <= 10'h000;
         flash <= !flash;
      end else if (ms_tick) begin
         flash_cnt <= flash_cnt + 10'h001;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         led_green <= 1'b0;
         led_yellow <= 1'b0;
      end else begin
         case (led_mode)
            PSOL_LED_SUPPLY: begin
               led_green <= (led_temp_en && temp_alarm) ? flash : 1'b1;
               led_yellow <= sw1;
            end
            PSOL_LED_OUT_ONLY: begin
               led_green <= 1'b0;
               led_yellow <= sw1;
            end
            default: begin
               led_green <= 1'b0;
               led_yellow <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// file: tb/psol_checker.sv
/*
 port checks of psol_top.
 assumes a bind to psol_top and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module psol_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic standard_switching_mode,
   input wire psol_pkg::psol_func_t func,
   input wire logic [2:0] step_out1,
   input wire logic [2:0] step_out2,
   input wire logic [15:0] start_delay_time,
   input wire logic signed [15:0] temp_c,
   input wire logic signed [15:0] temp_low,
   input wire logic signed [15:0] temp_high,
   input wire psol_pkg::psol_led_t led_mode,
   input wire logic param_rd,
   input wire logic param_valid,
   input wire logic [15:0] process_data,
   input wire logic update_request,
   input wire logic led_green,
   input wire logic led_yellow
);
   import psol_pkg::*;
   logic temp_out;
   assign temp_out = (temp_c < temp_low) || (temp_c > temp_high);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence link_rd;
      param_rd && !standard_switching_mode;
   endsequence
   // a clashing step pair freshly written in link mode
   sequence step_clash;
      !standard_switching_mode && func != PSOL_FN_SPEED && step_out1 <= step_out2
         && $changed({step_out1, step_out2});
   endsequence
   sequence speed_power_up;
      $rose(nrst) && func == PSOL_FN_SPEED && start_delay_time != 16'h0000;
   endsequence
   rd_answer_a: assert property (link_rd |=> param_valid)
      else $error("parameter read not answered");
   rd_refused_a: assert property (param_rd && standard_switching_mode |=> !param_valid)
      else $error("parameter read answered in standard mode");
   sio_quiet_a: assert property (
      standard_switching_mode [*3] |-> (process_data & 16'hFF5C) == 16'h0000)
      else $error("reporting extras present in standard mode");
   temp_alarm_a: assert property (
      (!standard_switching_mode && temp_out) [*3] |-> process_data[6])
      else $error("temperature excursion not reported");
   temp_clear_a: assert property ((!temp_out) [*3] |-> !process_data[6])
      else $error("temperature alarm without excursion");
   step_request_a: assert property (step_clash |-> ##[1:4] update_request)
      else $error("no update request after step correction");
   start_bit_a: assert property (
      speed_power_up |-> ##[1:3] (process_data[5] && process_data[1:0] == 2'b11))
      else $error("start delay not shown");
   no_start_a: assert property ((func != PSOL_FN_SPEED) [*3] |-> !process_data[5])
      else $error("start bit outside speed function");
   led_off_a: assert property (
      (led_mode == PSOL_LED_OFF) [*3] |-> !led_green && !led_yellow)
      else $error("led lit while off");
endmodule
`default_nettype wire

// file: tb/psol_plc_model.sv
/*
 far side of a switching output: a controller input with a load resistor.
 assumes pull_up picks a load to supply, otherwise to ground.
*/
`timescale 1ns/1ps
`default_nettype none
module psol_plc_model (
   input wire logic high_drive,
   input wire logic low_drive,
   input wire logic pull_up,
   output logic pin
);
   // a released output reads the load level, never the last driven value
   assign pin = high_drive ? 1'b1 : (low_drive ? 1'b0 : pull_up);
endmodule
`default_nettype wire

// file: tb/tb.sv
/*
 self-checking bench of psol_top, plc input model on output 1.
 assumes checker, model and design compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import psol_pkg::*;
   typedef struct {psol_outcfg_t cfg; logic [1:0] off; logic [1:0] on;} psol_row_t;
   logic clk = 1'b0, nrst = 1'b0, standard_switching_mode = 1'b0, hyst_small = 1'b0;
   logic speed_in_window = 1'b0, speed_above_min = 1'b0, hour_pulse = 1'b0;
   logic led_temp_en = 1'b0, mark_we = 1'b0, param_rd = 1'b0, pull_up = 1'b0;
   logic pin1, param_valid, update_request, out1_high_drive, out1_low_drive;
   logic out2_high_drive, out2_low_drive, led_green, led_yellow;
   psol_func_t func = PSOL_FN_ONE;
   psol_outcfg_t cfg_out1 = PSOL_PNP_NO, cfg_out2 = PSOL_PNP_NC;
   psol_led_t led_mode = PSOL_LED_SUPPLY;
   psol_unit_t temp_unit = PSOL_UNIT_C;
   logic [2:0] step_out1 = 3'h5, step_out2 = 3'h4, param_sel = 3'h0;
   logic [15:0] assert_delay_time = 16'h0000, release_delay_time = 16'h0000;
   logic [15:0] start_delay_time = 16'h0000, process_data, outs;
   logic [5:1] detect_std = 5'h00, detect_small = 5'h00;
   logic signed [15:0] temp_c = 16'h0019, temp_low = 16'hFFF6, temp_high = 16'h0050;
   logic [31:0] hours_limit = 32'hFFFF_FFFF, cycles_limit = 32'hFFFF_FFFF, param_rdata;
   logic [4:0] mark_addr = 5'h00;
   logic [7:0] mark_wdata = 8'h00;
   logic [1:0] e;
   int bad_count = 0;
   int check_count = 0;
   int req_count = 0;
   int n;
   // drive pairs {high, low}: not switched, switched
   psol_row_t rows [6] = '{
      '{PSOL_PNP_NO, 2'b00, 2'b10}, '{PSOL_PNP_NC, 2'b10, 2'b00},
      '{PSOL_NPN_NO, 2'b00, 2'b01}, '{PSOL_NPN_NC, 2'b01, 2'b00},
      '{PSOL_PP_NO, 2'b01, 2'b10}, '{PSOL_PP_NC, 2'b10, 2'b01}};
   assign outs = {10'h000, out1_high_drive, out1_low_drive, out2_high_drive, out2_low_drive,
      led_green, led_yellow};
   always #4 clk = ~clk;
   always @(posedge clk) if (update_request === 1'b1) req_count++;
   psol_top i_psol_top(.clk, .nrst, .standard_switching_mode, .func, .cfg_out1, .cfg_out2,
      .step_out1, .step_out2, .hyst_small, .assert_delay_time, .release_delay_time,
      .start_delay_time, .detect_std, .detect_small, .speed_in_window, .speed_above_min,
      .temp_c, .temp_low, .temp_high, .temp_unit, .hours_limit, .cycles_limit, .hour_pulse,
      .led_mode, .led_temp_en, .mark_we, .mark_addr, .mark_wdata, .param_rd, .param_sel,
      .param_rdata, .param_valid, .process_data, .update_request, .out1_high_drive,
      .out1_low_drive, .out2_high_drive, .out2_low_drive, .led_green, .led_yellow);
   psol_plc_model i_psol_plc_model(.high_drive(out1_high_drive), .low_drive(out1_low_drive),
      .pull_up, .pin(pin1));
   task automatic tick(input int k = 1);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // bounded wait; a run-out is a mismatch and ends the run
   task automatic wait_v(input string what, input bit sel, input logic [15:0] m, e);
      int k = 0;
      while (((sel ? outs : process_data) & m) !== e && k < 64) begin
         tick();
         k++;
      end
      chk(what, 32'(e), 32'((sel ? outs : process_data) & m));
      if (k == 64) end_sim();
   endtask
   task automatic rd_param(input logic [2:0] sel, input logic [31:0] exp, input string what);
      param_sel = sel;
      param_rd = 1'b1;
      tick();
      param_rd = 1'b0;
      chk("param valid", 32'(!standard_switching_mode), 32'(param_valid));
      if (!standard_switching_mode) chk(what, exp, param_rdata);
   endtask
   task automatic hold_chk(input string what, input logic v, input int cut);
      int c = 0;
      for (int i = 0; i < 300; i++) begin
         if (i == cut) detect_std = 5'h00;
         tick();
         c += 32'(process_data[0] !== v);
      end
      chk(what, 0, c);
   endtask
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      tick(4);
      nrst = 1'b1;
      tick(2);
      // configuration is taken every cycle in standard mode
      standard_switching_mode = 1'b1;
      foreach (rows[i]) begin
         for (int d = 0; d < 2; d++) begin
            cfg_out1 = rows[i].cfg;
            cfg_out2 = rows[i].cfg;
            pull_up = rows[i].cfg inside {PSOL_NPN_NO, PSOL_NPN_NC};
            detect_std = d ? 5'h1F : 5'h00;
            e = d ? rows[i].on : rows[i].off;
            tick();
            wait_v("drives", 1'b1, 16'h003F, {10'h000, e, e, 1'b1, d[0]});
            chk("pin1", 32'(d[0] ^ (rows[i].cfg inside {PSOL_PNP_NC, PSOL_NPN_NO, PSOL_PP_NC})),
               32'(pin1));
         end
      end
      for (int m = 1; m < 3; m++) begin
         led_mode = psol_led_t'(m);
         tick();
         wait_v("leds", 1'b1, 16'h0003, {15'h0000, m == 1});
      end
      led_mode = PSOL_LED_SUPPLY;
      cfg_out1 = PSOL_PNP_NO;
      cfg_out2 = PSOL_PNP_NO;
      tick();
      standard_switching_mode = 1'b0;
      hyst_small = 1'b1;
      wait_v("small hyst", 1'b0, 16'h0001, 16'h0000);
      detect_small = 5'h1F;
      wait_v("small hyst", 1'b0, 16'h0001, 16'h0001);
      detect_small = 5'h00;
      func = PSOL_FN_TWO;
      tick();
      wait_v("hyst ignored", 1'b0, 16'h0001, 16'h0001);
      func = PSOL_FN_ANALOG;
      for (int s = 0; s < 6; s++) begin
         detect_std = (s == 0) ? 5'h00 : 5'(5'h1F << (s - 1));
         tick();
         wait_v("analog code", 1'b0, 16'h001C, 16'((s == 0 ? 0 : 6 - s) << 2));
      end
      func = PSOL_FN_TWO;
      detect_std = 5'h18;
      n = req_count;
      step_out1 = 3'h2;
      step_out2 = 3'h3;
      wait_v("out1 raised", 1'b0, 16'h0003, 16'h0001);
      tick(4);
      chk("update request", n + 1, req_count);
      step_out1 = 3'h5;
      step_out2 = 3'h5;
      detect_std = 5'h10;
      wait_v("out2 lowered", 1'b0, 16'h0003, 16'h0001);
      tick(4);
      chk("update request", n + 2, req_count);
      step_out2 = 3'h4;
      temp_c = 16'h0064;
      wait_v("over temp", 1'b0, 16'h0040, 16'h0040);
      temp_c = 16'h0019;
      wait_v("temp ok", 1'b0, 16'h0040, 16'h0000);
      temp_c = 16'hFFEC;
      wait_v("under temp", 1'b0, 16'h0040, 16'h0040);
      led_temp_en = 1'b1;
      tick(2);
      chk("green flash", 32'h0, 32'(led_green));
      hours_limit = 32'h0000_0000;
      hour_pulse = 1'b1;
      tick();
      hour_pulse = 1'b0;
      wait_v("inspection", 1'b0, 16'h0080, 16'h0080);
      rd_param(3'h3, 32'h0000_0001, "hours");
      temp_unit = PSOL_UNIT_K;
      tick();
      rd_param(3'h0, 32'h0000_00FD, "kelvin");
      temp_unit = PSOL_UNIT_F;
      tick();
      rd_param(3'h0, 32'hFFFF_FFFC, "fahrenheit");
      mark_we = 1'b1;
      mark_wdata = 8'hA5;
      tick();
      mark_addr = 5'h1F;
      mark_wdata = 8'h3C;
      tick();
      mark_we = 1'b0;
      rd_param(3'h7, 32'h0000_003C, "last mark byte");
      wait_v("marking", 1'b0, 16'hFF00, 16'hA500);
      cfg_out2 = PSOL_INSP_ALARM;
      standard_switching_mode = 1'b1;
      tick();
      wait_v("sio extras", 1'b0, 16'hFF5C, 16'h0000);
      rd_param(3'h3, 32'h0000_0000, "hours");
      wait_v("insp excluded", 1'b1, 16'h000C, 16'h0000);
      standard_switching_mode = 1'b0;
      func = PSOL_FN_ONE;
      hyst_small = 1'b0;
      detect_std = 5'h00;
      assert_delay_time = 16'h0001;
      wait_v("idle", 1'b0, 16'h0001, 16'h0000);
      wait_v("insp out2", 1'b1, 16'h000C, 16'h0008);
      detect_std = 5'h1F;
      hold_chk("short pulse", 1'b0, 100);
      assert_delay_time = 16'h0000;
      release_delay_time = 16'h0001;
      detect_std = 5'h1F;
      wait_v("no on delay", 1'b0, 16'h0001, 16'h0001);
      hold_chk("gap bridged", 1'b1, 0);
      nrst = 1'b0;
      func = PSOL_FN_SPEED;
      start_delay_time = 16'h0001;
      tick(4);
      nrst = 1'b1;
      tick();
      wait_v("start delay", 1'b0, 16'h0023, 16'h0023);
      wait_v("start drives", 1'b1, 16'h003C, 16'h0028);
      end_sim();
   end
endmodule
bind psol_top psol_checker i_psol_checker(.clk, .nrst, .standard_switching_mode, .func,
   .step_out1, .step_out2, .start_delay_time, .temp_c, .temp_low, .temp_high, .led_mode,
   .param_rd, .param_valid, .process_data, .update_request, .led_green, .led_yellow);
`default_nettype wire
